// [pkg/i2cna_pkg.sv]
// Constants, carriers and state types for the acknowledge, arbitration and SCL low-time block
package i2cna_pkg;
    // ==========================================================
    // Register byte offsets on the APB
    localparam logic [7:0] I2CNA_ADDR_STATUS = 8'h00; // Flags, bus-busy view
    localparam logic [7:0] I2CNA_ADDR_ISRC = 8'h04; // Interrupt source register
    localparam logic [7:0] I2CNA_ADDR_MODE = 8'h08; // Mode register
    localparam logic [7:0] I2CNA_ADDR_LOWDIV = 8'h0c; // SCL low divider register
    localparam logic [7:0] I2CNA_ADDR_HIGHDIV = 8'h10; // SCL high divider register

    // ==========================================================
    // Field positions
    localparam int I2CNA_STAT_AL_BIT = 0; // Arbitration-lost flag
    localparam int I2CNA_STAT_NACK_BIT = 1; // No-acknowledge flag
    localparam int I2CNA_STAT_BB_BIT = 12; // Bus busy, read only
    localparam int I2CNA_MODE_MST_BIT = 10; // Master select
    localparam int I2CNA_MODE_STP_BIT = 11; // Stop request
    localparam int I2CNA_MODE_STT_BIT = 13; // Start request, self clearing
    localparam int I2CNA_MODE_OOR_BIT = 5; // Module out of reset
    localparam int I2CNA_DIV_MSB = 15; // Top bit of a divide field

    // ==========================================================
    // Reset values and codes
    localparam logic [15:0] I2CNA_DIV_RESET = 16'h0000; // Divide fields after reset
    localparam logic [31:0] I2CNA_ZERO_WORD = 32'h0000_0000; // Reserved bits, idle data
    localparam logic [2:0] I2CNA_ISRC_NONE = 3'h0; // No pending source
    localparam logic [2:0] I2CNA_ISRC_AL = 3'h1; // Arbitration lost
    localparam logic [2:0] I2CNA_ISRC_NACK = 3'h2; // No acknowledge

    // ==========================================================
    // Timing: SCL phase length is (divide value + offset) module clocks
    localparam logic [16:0] I2CNA_DIV_OFFSET = 17'h0_0006; // Fixed added cycles
    localparam logic [16:0] I2CNA_DIV_LAST = I2CNA_DIV_OFFSET - 17'h0_0001; // Last count

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic ack_valid; // One-cycle pulse: acknowledge slot sampled
        logic nack; // Sampled slot held a no-acknowledge
        logic gen_call; // Transfer in progress is a general call
        logic arb_lost; // One-cycle pulse: arbitration contest lost
    } i2cna_serial_evt_t;

    typedef struct packed {
        logic out_of_reset; // Module released from reset
        logic master_sel; // Master role selected
        logic stop_req; // Stop condition requested
    } i2cna_mode_t;

    typedef enum logic [1:0] {SCL_IDLE, SCL_LOW, SCL_HIGH} i2cna_scl_state_t;
endpackage

// [src/i2cna_core.sv]
// Flag, interrupt source and SCL divider logic with its APB register file
//
// Operation
// - Transmitter sees no-acknowledge: set nack flag
// - Later acknowledge clears the nack flag
// - Write one clears nack; zero keeps it
// - Reading nack source code clears nack
// - Module reset clears both flags
// - General call keeps nack reading set
// - Lost arbitration sets arbitration-lost flag
// - Start while bus busy sets arbitration-lost
// - Write one clears arbitration-lost flag
// - Reading arbitration source code clears it
// - Arbitration lost drops master and stop
// - Nack is pollable flag and interrupt
// - Arbitration-lost is pollable flag and interrupt
// - Master SCL divided from module clock
// - Low phase lasts divide value plus six
// - Divider upper half reads zero, resets zero
`timescale 1ns/1ps
module i2cna_core (
    input wire logic pclk, // Module clock, 125 MHz
    input wire logic presetn, // Asynchronous chip reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction, high for write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error for unmapped address
    input wire i2cna_pkg::i2cna_serial_evt_t serial_evt, // Events from the shifter
    input wire logic bus_busy, // Bus busy from the line monitor
    output logic nack_irq, // No-acknowledge interrupt request
    output logic al_irq, // Arbitration-lost interrupt request
    output logic master_active, // Master select bit of the mode register
    output logic stop_pending, // Stop request bit of the mode register
    output logic start_go, // One-cycle pulse: start accepted
    output logic scl_o, // SCL drive level, always low
    output logic scl_oe // SCL output enable, high while pulling low
);
    import i2cna_pkg::*;

    // ==========================================================
    // State
    logic nack_flag_r; // No-acknowledge flag
    logic al_flag_r; // Arbitration-lost flag
    i2cna_mode_t mode_r; // Mode register fields
    logic [15:0] low_div_r; // SCL low divide value
    logic [15:0] high_div_r; // SCL high divide value
    logic [31:0] prdata_r; // Registered read data
    logic pready_r; // Registered ready
    logic pslverr_r; // Registered error
    logic [2:0] isrc_code_r; // Source code handed out on the current read
    logic start_go_r; // Start accepted pulse
    i2cna_scl_state_t scl_state_r; // SCL generator phase
    logic [16:0] scl_cnt_r; // Cycles spent in the current phase
    logic scl_oe_r; // SCL pull-low enable

    // ==========================================================
    // Bus decode
    logic acc; // Access phase completes at this edge
    logic wr_acc; // Completing write
    logic rd_acc; // Completing read
    logic mapped; // Address hits a register
    logic start_try; // Software asks for a start
    logic al_set; // Any arbitration-lost cause this cycle
    logic nack_set; // Any no-acknowledge cause this cycle

    // Source code priority: arbitration lost first, then no-acknowledge
    function automatic logic [2:0] isrc_of(input logic al, input logic nack);
        if (al) begin
            return I2CNA_ISRC_AL;
        end else if (nack) begin
            return I2CNA_ISRC_NACK;
        end
        return I2CNA_ISRC_NONE;
    endfunction

    // Address map check for the error response; the read path decodes paddr itself
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == I2CNA_ADDR_STATUS) || (a == I2CNA_ADDR_ISRC) || (a == I2CNA_ADDR_MODE)
            || (a == I2CNA_ADDR_LOWDIV) || (a == I2CNA_ADDR_HIGHDIV);
    endfunction

    assign acc = psel && penable && pready_r;
    assign wr_acc = acc && pwrite && !pslverr_r;
    assign rd_acc = acc && !pwrite && !pslverr_r;
    assign mapped = is_mapped(paddr);
    // A start counts only when it is written together with master select
    assign start_try = wr_acc && (paddr == I2CNA_ADDR_MODE) && pwdata[I2CNA_MODE_STT_BIT]
        && pwdata[I2CNA_MODE_MST_BIT] && mode_r.out_of_reset;
    assign al_set = mode_r.out_of_reset && (serial_evt.arb_lost
        || (start_try && bus_busy));
    // General call forces the flag even on an acknowledge
    assign nack_set = mode_r.out_of_reset && serial_evt.ack_valid
        && (serial_evt.nack || serial_evt.gen_call);

    // ==========================================================
    // APB slave: one wait state, so every answer leaves a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= I2CNA_ZERO_WORD;
            isrc_code_r <= I2CNA_ISRC_NONE;
        end else if (psel && penable && !pready_r) begin
            // First access cycle: prepare the answer
            pready_r <= 1'b1;
            pslverr_r <= !mapped;
            prdata_r <= I2CNA_ZERO_WORD;
            isrc_code_r <= I2CNA_ISRC_NONE;
            if (!pwrite) begin
                unique case (paddr)
                    I2CNA_ADDR_STATUS: begin
                        prdata_r[I2CNA_STAT_AL_BIT] <= al_flag_r;
                        prdata_r[I2CNA_STAT_NACK_BIT] <= nack_flag_r;
                        prdata_r[I2CNA_STAT_BB_BIT] <= bus_busy;
                    end
                    I2CNA_ADDR_ISRC: begin
                        // Latch the code so the clear matches what software saw
                        prdata_r[2:0] <= isrc_of(al_flag_r, nack_flag_r);
                        isrc_code_r <= isrc_of(al_flag_r, nack_flag_r);
                    end
                    I2CNA_ADDR_MODE: begin
                        prdata_r[I2CNA_MODE_OOR_BIT] <= mode_r.out_of_reset;
                        prdata_r[I2CNA_MODE_MST_BIT] <= mode_r.master_sel;
                        prdata_r[I2CNA_MODE_STP_BIT] <= mode_r.stop_req;
                    end
                    I2CNA_ADDR_LOWDIV: begin
                        prdata_r[I2CNA_DIV_MSB:0] <= low_div_r;
                    end
                    I2CNA_ADDR_HIGHDIV: begin
                        prdata_r[I2CNA_DIV_MSB:0] <= high_div_r;
                    end
                    default: begin
                        prdata_r <= I2CNA_ZERO_WORD; // Unmapped reads return zero
                    end
                endcase
            end
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // ==========================================================
    // No-acknowledge flag: hardware set beats every clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nack_flag_r <= 1'b0;
        end else if (!mode_r.out_of_reset) begin
            nack_flag_r <= 1'b0;
        end else if (nack_set) begin
            nack_flag_r <= 1'b1;
        end else if (serial_evt.ack_valid) begin
            nack_flag_r <= 1'b0;
        end else if (wr_acc && paddr == I2CNA_ADDR_STATUS && pwdata[I2CNA_STAT_NACK_BIT]) begin
            nack_flag_r <= 1'b0;
        end else if (rd_acc && paddr == I2CNA_ADDR_ISRC && isrc_code_r == I2CNA_ISRC_NACK) begin
            nack_flag_r <= 1'b0;
        end
    end

    // ==========================================================
    // Arbitration-lost flag: stays until one of its clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            al_flag_r <= 1'b0;
        end else if (!mode_r.out_of_reset) begin
            al_flag_r <= 1'b0;
        end else if (al_set) begin
            al_flag_r <= 1'b1;
        end else if (wr_acc && paddr == I2CNA_ADDR_STATUS && pwdata[I2CNA_STAT_AL_BIT]) begin
            al_flag_r <= 1'b0;
        end else if (rd_acc && paddr == I2CNA_ADDR_ISRC && isrc_code_r == I2CNA_ISRC_AL) begin
            al_flag_r <= 1'b0;
        end
    end

    // ==========================================================
    // Mode register: a lost contest demotes to slave-receiver
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= '0;
        end else if (al_set) begin
            // Software may still move the reset bit in the same write
            if (wr_acc && paddr == I2CNA_ADDR_MODE) begin
                mode_r.out_of_reset <= pwdata[I2CNA_MODE_OOR_BIT];
            end
            mode_r.master_sel <= 1'b0;
            mode_r.stop_req <= 1'b0;
        end else if (wr_acc && paddr == I2CNA_ADDR_MODE) begin
            mode_r.out_of_reset <= pwdata[I2CNA_MODE_OOR_BIT];
            mode_r.master_sel <= pwdata[I2CNA_MODE_MST_BIT];
            mode_r.stop_req <= pwdata[I2CNA_MODE_STP_BIT];
        end
    end

    // Start pulse toward the shifter when the bus is free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_go_r <= 1'b0;
        end else begin
            start_go_r <= start_try && !bus_busy;
        end
    end

    // ==========================================================
    // Divider registers: sixteen bits kept, upper half dropped on write.
    // Changing them with the module running gives one odd-length phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_div_r <= I2CNA_DIV_RESET;
            high_div_r <= I2CNA_DIV_RESET;
        end else if (wr_acc) begin
            if (paddr == I2CNA_ADDR_LOWDIV) begin
                low_div_r <= pwdata[I2CNA_DIV_MSB:0];
            end
            if (paddr == I2CNA_ADDR_HIGHDIV) begin
                high_div_r <= pwdata[I2CNA_DIV_MSB:0];
            end
        end
    end

    // ==========================================================
    // SCL generator: low for low_div+6 clocks, high for high_div+6
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_state_r <= SCL_IDLE;
            scl_cnt_r <= '0;
            scl_oe_r <= 1'b0;
        end else if (!(mode_r.master_sel && mode_r.out_of_reset)) begin
            // Slave role or held in reset: release the line
            scl_state_r <= SCL_IDLE;
            scl_cnt_r <= '0;
            scl_oe_r <= 1'b0;
        end else begin
            unique case (scl_state_r)
                SCL_IDLE: begin
                    scl_state_r <= SCL_LOW;
                    scl_cnt_r <= '0;
                    scl_oe_r <= 1'b1;
                end
                SCL_LOW: begin
                    if (scl_cnt_r == {1'b0, low_div_r} + I2CNA_DIV_LAST) begin
                        scl_state_r <= SCL_HIGH;
                        scl_cnt_r <= '0;
                        scl_oe_r <= 1'b0;
                    end else begin
                        scl_cnt_r <= scl_cnt_r + 17'h0_0001;
                    end
                end
                SCL_HIGH: begin
                    if (scl_cnt_r == {1'b0, high_div_r} + I2CNA_DIV_LAST) begin
                        scl_state_r <= SCL_LOW;
                        scl_cnt_r <= '0;
                        scl_oe_r <= 1'b1;
                    end else begin
                        scl_cnt_r <= scl_cnt_r + 17'h0_0001;
                    end
                end
                default: begin
                    // Unused state code: fall back to a released line
                    scl_state_r <= SCL_IDLE;
                    scl_cnt_r <= '0;
                    scl_oe_r <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Outputs, all from flip-flops except scl_o, which is tied low
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign nack_irq = nack_flag_r;
    assign al_irq = al_flag_r;
    assign master_active = mode_r.master_sel;
    assign stop_pending = mode_r.stop_req;
    assign start_go = start_go_r;
    assign scl_o = 1'b0; // Open drain: only ever pulls low
    assign scl_oe = scl_oe_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [16:0] lo_len_q; // Cycles the line has been pulled low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lo_len_q <= '0;
        end else begin
            lo_len_q <= scl_oe_r ? lo_len_q + 17'h0_0001 : 17'h0_0000;
        end
    end

    chk_nack_set_on: assert property (nack_set |=> nack_flag_r)
        else $error("nack flag not set after no-acknowledge");
    chk_nack_ack_clear: assert property (
        mode_r.out_of_reset && serial_evt.ack_valid && !serial_evt.nack
        && !serial_evt.gen_call |=> !nack_flag_r)
        else $error("nack flag not cleared by acknowledge");
    chk_nack_w1c: assert property (
        nack_flag_r && mode_r.out_of_reset && !nack_set && !serial_evt.ack_valid && wr_acc
        && paddr == I2CNA_ADDR_STATUS
        |=> nack_flag_r == !$past(pwdata[I2CNA_STAT_NACK_BIT]))
        else $error("nack write-one-to-clear misbehaves");
    chk_nack_isrc_clear: assert property (
        rd_acc && paddr == I2CNA_ADDR_ISRC
        && prdata_r[2:0] == I2CNA_ISRC_NACK && !nack_set |=> !nack_flag_r)
        else $error("nack source read did not clear flag");
    chk_flags_mod_reset: assert property (
        !mode_r.out_of_reset |=> !nack_flag_r && !al_flag_r)
        else $error("flags survive module reset");
    chk_gen_call_nack: assert property (
        mode_r.out_of_reset && serial_evt.ack_valid && serial_evt.gen_call |=> nack_flag_r)
        else $error("general call did not set nack");
    chk_al_set_on: assert property (
        mode_r.out_of_reset && serial_evt.arb_lost
        |=> al_flag_r && !mode_r.master_sel && !mode_r.stop_req)
        else $error("arbitration loss not handled");
    chk_al_busy_start: assert property (
        start_try && bus_busy |=> al_flag_r && !start_go_r)
        else $error("busy start not flagged");
    chk_al_w1c: assert property (
        al_flag_r && !al_set && wr_acc && paddr == I2CNA_ADDR_STATUS
        && pwdata[I2CNA_STAT_AL_BIT] |=> !al_flag_r)
        else $error("arbitration flag not cleared by write");
    chk_al_isrc_clear: assert property (
        rd_acc && paddr == I2CNA_ADDR_ISRC
        && prdata_r[2:0] == I2CNA_ISRC_AL && !al_set |=> !al_flag_r)
        else $error("arbitration source read did not clear flag");
    chk_irq_hold: assert property (
        nack_flag_r && mode_r.out_of_reset && !serial_evt.ack_valid && !wr_acc && !rd_acc
        |=> nack_irq)
        else $error("nack request dropped without a clear");
    chk_al_hold: assert property (
        al_flag_r && mode_r.out_of_reset && !wr_acc && !rd_acc |=> al_irq)
        else $error("arbitration request dropped without a clear");
    chk_low_time: assert property (
        $fell(scl_oe_r) && mode_r.master_sel
        |-> lo_len_q == {1'b0, low_div_r} + I2CNA_DIV_OFFSET)
        else $error("SCL low phase length wrong");
    chk_div_upper_zero: assert property (
        pready_r && !pwrite && paddr == I2CNA_ADDR_LOWDIV |-> prdata_r[31:16] == 16'h0000)
        else $error("divider upper half not zero");

    cov_nack_seen: cover property (nack_set ##1 nack_irq);
    cov_busy_start: cover property (start_try && bus_busy);
    cov_low_phase: cover property ($rose(scl_oe_r) ##[1:40] $fell(scl_oe_r));
    cov_isrc_read: cover property (rd_acc && paddr == I2CNA_ADDR_ISRC && isrc_code_r != 3'h0);
endmodule

// [verif/i2cna_bus_peer.sv]
// Model of the other masters and slaves on the two-wire bus
`timescale 1ns/1ps
module i2cna_bus_peer (
    input wire logic pclk, // Module clock
    input wire logic presetn, // Chip reset, active low
    input wire logic [2:0] kind, // Slot to play: 1 ack, 2 nack, 3 general call, 4 lost
    input wire logic busy_in, // Another master holds the bus
    output i2cna_pkg::i2cna_serial_evt_t serial_evt, // Events towards the block
    output logic bus_busy // Bus busy seen on the lines
);
    import i2cna_pkg::*;
    // ==========================================================
    // Event player, one pulse per requested slot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_evt <= '0;
            bus_busy <= 1'b0;
        end else begin
            bus_busy <= busy_in;
            serial_evt.ack_valid <= (kind == 3'h1) || (kind == 3'h2) || (kind == 3'h3);
            serial_evt.arb_lost <= (kind == 3'h4);
            // Outside a slot the qualifiers toggle, so a stale level is never trusted
            serial_evt.nack <= (kind == 3'h2) | ((kind == 3'h0) & ~serial_evt.nack);
            serial_evt.gen_call <= (kind == 3'h3) | ((kind == 3'h0) & ~serial_evt.gen_call);
        end
    end
endmodule

// [verif/i2c_nack_arbitration_scl_low_bench.sv]
// Self-checking bench for the acknowledge, arbitration and SCL low-time block
`timescale 1ns/1ps
module i2c_nack_arbitration_scl_low_bench;
    import i2cna_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e; // Clock, reset, APB
    logic [7:0] paddr; // APB address
    logic [31:0] pwdata, prdata, q, w; // APB data, last read, scratch
    i2cna_serial_evt_t serial_evt; // Peer events
    logic bus_busy, nack_irq, al_irq, master_active, stop_pending, start_go, scl_o, scl_oe;
    logic [2:0] kind; // Slot requested from the peer
    logic busy_in; // Bus busy requested from the peer
    int n_errors, n_tests, n_go, seed, lo, hi, g0;

    i2cna_core i_i2cna_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_evt(serial_evt), .bus_busy(bus_busy), .nack_irq(nack_irq),
        .al_irq(al_irq), .master_active(master_active), .stop_pending(stop_pending),
        .start_go(start_go), .scl_o(scl_o), .scl_oe(scl_oe));
    i2cna_bus_peer i_i2cna_bus_peer (.pclk(pclk), .presetn(presetn), .kind(kind),
        .busy_in(busy_in), .serial_evt(serial_evt), .bus_busy(bus_busy));

    // ==========================================================
    // Clock and watchdog; the whole run needs a few hundred cycles
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        end_sim();
    end
    // Start pulses last one cycle, so they are counted here
    always @(posedge pclk) if (start_go === 1'b1) n_go <= n_go + 1;

    // ==========================================================
    // Expectation helpers
    function automatic logic [31:0] stat(input logic al, input logic nk, input logic bb);
        stat = I2CNA_ZERO_WORD;
        stat[I2CNA_STAT_AL_BIT] = al;
        stat[I2CNA_STAT_NACK_BIT] = nk;
        stat[I2CNA_STAT_BB_BIT] = bb;
    endfunction
    function automatic logic [31:0] mode(input logic oor, input logic master_select_bit, input logic stop_request_bit,
                                         input logic stt);
        mode = I2CNA_ZERO_WORD;
        mode[I2CNA_MODE_OOR_BIT] = oor;
        mode[I2CNA_MODE_MST_BIT] = master_select_bit;
        mode[I2CNA_MODE_STP_BIT] = stop_request_bit;
        mode[I2CNA_MODE_STT_BIT] = stt;
    endfunction

    // ==========================================================
    // Bus tasks; each is entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // The slave sets the pace; only the watchdog ends a wait that never ends
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge so the next request never lands in this time step
        @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic peer(input logic [2:0] k);
        kind <= k;
        @(posedge pclk);
        kind <= 3'h0;
        repeat (3) @(posedge pclk);
    endtask
    // Length of one SCL low phase and the following high phase, a full period in
    task automatic measure();
        #1;
        while (scl_oe === 1'b1) begin @(posedge pclk); #1; end
        while (scl_oe === 1'b0) begin @(posedge pclk); #1; end
        lo = 0;
        hi = 0;
        while (scl_oe === 1'b1 && lo < 300) begin @(posedge pclk); #1; lo++; end
        while (scl_oe === 1'b0 && hi < 300) begin @(posedge pclk); #1; hi++; end
        @(posedge pclk);
    endtask
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        seed = 32'h669c_166e;
        {presetn, psel, penable, pwrite, busy_in} = 5'h00;
        {paddr, pwdata, kind} = '0;
        {n_errors, n_tests, n_go} = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, I2CNA_ADDR_LOWDIV, 32'h0); chk(q, 32'h0);
        apb(1'b0, I2CNA_ADDR_STATUS, 32'h0); chk(q, stat(0, 0, 0));
        w = $random(seed);
        apb(1'b1, I2CNA_ADDR_LOWDIV, w);
        apb(1'b0, I2CNA_ADDR_LOWDIV, 32'h0); chk(q, {16'h0000, w[15:0]});
        apb(1'b1, 8'h14, w);
        apb(1'b0, 8'h14, 32'h0); chk({q[30:0], e}, 32'h1); // Unmapped refused
        $display("test registers done");
        // Dividers are set in module reset, then the master clock is measured
        for (int i = 0; i < 3; i++) begin
            w = $random(seed) & 32'hffff_000f;
            if (i == 0) w[15:0] = 16'h0000;
            apb(1'b1, I2CNA_ADDR_LOWDIV, w);
            apb(1'b1, I2CNA_ADDR_HIGHDIV, w ^ 32'h0000_0005);
            apb(1'b1, I2CNA_ADDR_MODE, mode(1, 1, 0, 0));
            measure();
            chk(lo, w[15:0] + 16'h0006);
            chk(hi, (w[15:0] ^ 16'h0005) + 16'h0006);
            chk(scl_o, 1'b0);
            apb(1'b1, I2CNA_ADDR_MODE, mode(0, 0, 0, 0));
        end
        $display("test divider done");
        apb(1'b1, I2CNA_ADDR_MODE, mode(1, 0, 0, 0));
        peer(3'h2); chk(nack_irq, 1);
        apb(1'b0, I2CNA_ADDR_STATUS, 32'h0); chk(q, stat(0, 1, 0));
        peer(3'h1); chk(nack_irq, 1'b0);
        apb(1'b0, I2CNA_ADDR_STATUS, 32'h0); chk(q, stat(0, 0, 0));
        peer(3'h2);
        apb(1'b1, I2CNA_ADDR_STATUS, 32'hffff_fffd);
        apb(1'b0, I2CNA_ADDR_STATUS, 32'h0); chk(q, stat(0, 1, 0));
        apb(1'b1, I2CNA_ADDR_STATUS, 32'h0000_0002);
        apb(1'b0, I2CNA_ADDR_STATUS, 32'h0); chk(q, stat(0, 0, 0));
        peer(3'h3);
        apb(1'b0, I2CNA_ADDR_ISRC, 32'h0); chk(q, {29'h0, I2CNA_ISRC_NACK});
        apb(1'b0, I2CNA_ADDR_STATUS, 32'h0); chk(q, stat(0, 0, 0));
        $display("test acknowledge done");
        apb(1'b1, I2CNA_ADDR_MODE, mode(1, 1, 1, 0)); chk(stop_pending, 1);
        peer(3'h4); chk({master_active, stop_pending}, 32'h0);
        chk(al_irq, 1);
        apb(1'b0, I2CNA_ADDR_MODE, 32'h0); chk(q, mode(1, 0, 0, 0));
        peer(3'h2);
        apb(1'b0, I2CNA_ADDR_STATUS, 32'h0); chk(q, stat(1, 1, 0));
        apb(1'b0, I2CNA_ADDR_ISRC, 32'h0); chk(q, {29'h0, I2CNA_ISRC_AL});
        apb(1'b0, I2CNA_ADDR_ISRC, 32'h0); chk(q, {29'h0, I2CNA_ISRC_NACK});
        apb(1'b0, I2CNA_ADDR_ISRC, 32'h0); chk(q, {29'h0, I2CNA_ISRC_NONE});
        peer(3'h4);
        apb(1'b1, I2CNA_ADDR_STATUS, 32'h0000_0001);
        apb(1'b0, I2CNA_ADDR_STATUS, 32'h0); chk(q, stat(0, 0, 0));
        peer(3'h2);
        repeat (40) @(posedge pclk);
        chk(nack_irq, 1);
        $display("test arbitration done");
        g0 = n_go;
        apb(1'b1, I2CNA_ADDR_MODE, mode(1, 1, 0, 1));
        repeat (3) @(posedge pclk);
        chk(n_go, g0 + 1);
        busy_in <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b1, I2CNA_ADDR_MODE, mode(1, 1, 1, 1));
        apb(1'b0, I2CNA_ADDR_STATUS, 32'h0); chk(q, stat(1, 1, 1));
        chk(n_go, g0 + 1);
        chk({master_active, stop_pending}, 32'h0);
        apb(1'b1, I2CNA_ADDR_MODE, mode(0, 0, 0, 0));
        apb(1'b0, I2CNA_ADDR_STATUS, 32'h0); chk({30'h0, q[1:0]}, 32'h0);
        chk({nack_irq, al_irq}, 32'h0);
        // Chip reset in mid-run with a flag up and the divider loaded
        apb(1'b1, I2CNA_ADDR_MODE, mode(1, 0, 0, 0));
        peer(3'h2); chk(nack_irq, 1);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({nack_irq, al_irq, master_active}, 32'h0);
        apb(1'b0, I2CNA_ADDR_LOWDIV, 32'h0); chk(q, 32'h0);
        $display("test start and module reset done");
        end_sim();
    end
endmodule
